// ===== scb_pkg.sv
/*
 package for the two-wire serial clock, data buffer and port block.
 assumes a 200 MHz system clock and a classic wishbone register bus.
*/
package scb_pkg;
    localparam int unsigned SCB_CLK_MHZ = 200;
    // register byte addresses are the register index times four
    localparam logic [15:0] SCB_IDX_RATE = 16'h7f62;
    localparam logic [15:0] SCB_IDX_DATA = 16'h7f63;
    localparam logic [15:0] SCB_IDX_PORT = 16'h7f68;
    localparam logic [15:0] SCB_IDX_CTRL = 16'h7f69;
    localparam logic [15:0] SCB_IDX_PFN = 16'h7f6a;
    localparam logic [17:0] SCB_ADR_RATE = {SCB_IDX_RATE, 2'b00};
    localparam logic [17:0] SCB_ADR_DATA = {SCB_IDX_DATA, 2'b00};
    localparam logic [17:0] SCB_ADR_PORT = {SCB_IDX_PORT, 2'b00};
    localparam logic [17:0] SCB_ADR_CTRL = {SCB_IDX_CTRL, 2'b00};
    localparam logic [17:0] SCB_ADR_PFN = {SCB_IDX_PFN, 2'b00};
    // rate register fields
    localparam int unsigned SCB_PRE_HI = 7;
    localparam int unsigned SCB_PRE_LO = 6;
    localparam int unsigned SCB_SPEED_BIT = 5;
    localparam int unsigned SCB_DIV_HI = 4;
    // port control fields
    localparam int unsigned SCB_SLOW_BIT = 0;
    localparam int unsigned SCB_THR_BIT = 1;
    localparam int unsigned SCB_PV_BIT = 2;
    localparam int unsigned SCB_HOLD_BIT = 3;
    // control register fields
    localparam int unsigned SCB_MODE_BIT = 0;
    localparam int unsigned SCB_MST_BIT = 1;
    localparam int unsigned SCB_XMIT_BIT = 2;
    localparam int unsigned SCB_END_BIT = 3;
    localparam int unsigned SCB_RUN_BIT = 4;
    // reset values
    localparam logic [7:0] SCB_RATE_RST = 8'h00;
    localparam logic [7:0] SCB_DATA_RST = 8'h00;
    localparam logic [3:0] SCB_PORT_RST = 4'h0;
    localparam logic [4:0] SCB_CTRL_RST = 5'h00;
    localparam logic [11:0] SCB_PFN_RST = 12'h000;
    // standard-mode half period multiplier
    localparam int unsigned SCB_STD_MULT = 4;
    localparam int unsigned SCB_BITS = 8;
    typedef enum logic [1:0] {
        SCB_PIN_OPEN = 2'b00,
        SCB_PIN_CMOS = 2'b01,
        SCB_PIN_SLOW = 2'b11,
        SCB_PIN_OD = 2'b10
    } scb_pin_t;
endpackage

// ===== scb_pin_cfg.sv
/*
 output-type decode and drive for one serial pin.
 assumes function, latch and direction bits come from software.
*/
`timescale 1ns/100ps
module scb_pin_cfg
    import scb_pkg::*;
(
    input wire logic fsa_i,
    input wire logic fsb_i,
    input wire logic lat_i,
    input wire logic ddr_i,
    input wire logic slow_force_i,
    input wire logic val_i,
    output scb_pin_t type_o,
    output logic out_o,
    output logic oe_o
);
    scb_pin_t t;
    always_comb begin
        t = SCB_PIN_OPEN;
        if (fsa_i) begin
            unique case ({fsb_i, lat_i, ddr_i})
                3'b001: t = SCB_PIN_CMOS;
                3'b110: t = SCB_PIN_SLOW;
                3'b101: t = SCB_PIN_OD;
                default: t = SCB_PIN_OPEN;
            endcase
        end
        if (slow_force_i && t == SCB_PIN_CMOS) begin
            t = SCB_PIN_SLOW;
        end
    end
    assign type_o = t;
    always_comb begin
        out_o = val_i;
        oe_o = 1'b0;
        unique case (t)
            SCB_PIN_CMOS, SCB_PIN_SLOW: oe_o = 1'b1;
            SCB_PIN_OD: begin
                out_o = 1'b0;
                oe_o = ~val_i;
            end
            default: oe_o = 1'b0;
        endcase
    end
endmodule

// ===== scb_top.sv
/*
 serial clock generator, data buffer and port configuration of a two-wire unit.
 assumes the start/stop/ack logic outside supplies start, end and shift events.
*/
`timescale 1ns/100ps
// What this block does
// - clock period is filter period times (n+1) times 2 or 8
// - filter period comes from system clock scaled by prescale field
// - sync master mode period is also filter period times (n+1) times 2 or 8
// - i2c mode loads buffer from receive shifter at eighth falling edge
// - sync mode loads buffer from receive shifter at eighth rising edge
// - i2c transmit loads shifter on start or buffer write while end set
// - sync transmit loads shifter on buffer write while master flag clear
// - one 8-bit read/write data buffer, zero after reset
// - slow bit turns cmos drive into slow drive on both serial pins
// - clock pin type chosen from its function, latch, direction bits
// - data pin input always enabled, output type from its bits
// - 3-wire mode data output pin type from its bits
// - mode bit 1 selects sync mode without filter, 0 i2c with filter
// - prescale 00..11 gives filter period of 1..4 system clocks
// - generated clock has fifty percent duty
module scb_top
    import scb_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [17:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic start_det_i,
    input wire logic end_set_i,
    input wire logic ext_clk_i,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic sdo_o,
    output logic sdo_oe_o,
    output logic sda_in_en_o,
    output logic cmos_threshold_o,
    output logic slow_drive_o,
    output logic port_voltage_o,
    output logic sda_hold_adjust_o,
    output logic filter_en_o,
    output logic xfer_done_o
);
    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] rate_q, rate_d;
    logic [7:0] buf_q, buf_d;
    logic [3:0] port_q, port_d;
    logic [4:0] ctrl_q, ctrl_d;
    logic [11:0] pfn_q, pfn_d;
    logic ack_q, ack_d;
    logic err_q, err_d;
    logic [31:0] rdat_q, rdat_d;
    logic [7:0] tx_q, tx_d;
    logic [7:0] rx_q, rx_d;
    logic [3:0] cnt_q, cnt_d;
    logic done_q, done_d;
    // clock generator state
    logic [1:0] pre_q, pre_d;
    logic [6:0] div_q, div_d;
    logic sck_q, sck_d;
    logic ext_q, ext_d;

    logic sync_mode, master, xmit, end_flag, run;
    logic req, wr, hit_rate, hit_data, hit_port, hit_ctrl, hit_pfn, hit_any;
    logic buf_wr, tick, sck_fall, sck_rise, ext_mode;
    logic [6:0] half_lim;
    logic [31:0] rd_mux;

    assign sync_mode = ctrl_q[SCB_MODE_BIT];
    assign master = ctrl_q[SCB_MST_BIT];
    assign xmit = ctrl_q[SCB_XMIT_BIT];
    assign end_flag = ctrl_q[SCB_END_BIT];
    assign run = ctrl_q[SCB_RUN_BIT];
    assign filter_en_o = ~sync_mode;

    ////////////////////////////////////////////////////////////////////////////
    // wishbone slave
    assign req = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign hit_rate = wb_adr_i == SCB_ADR_RATE;
    assign hit_data = wb_adr_i == SCB_ADR_DATA;
    assign hit_port = wb_adr_i == SCB_ADR_PORT;
    assign hit_ctrl = wb_adr_i == SCB_ADR_CTRL;
    assign hit_pfn = wb_adr_i == SCB_ADR_PFN;
    assign hit_any = hit_rate | hit_data | hit_port | hit_ctrl | hit_pfn;
    assign buf_wr = wr & hit_data;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_rate) begin
            rd_mux = {24'h00_0000, rate_q};
        end
        if (hit_data) begin
            rd_mux = {24'h00_0000, buf_q};
        end
        if (hit_port) begin
            rd_mux = {28'h000_0000, port_q};
        end
        if (hit_ctrl) begin
            rd_mux = {27'h000_0000, ctrl_q};
        end
        if (hit_pfn) begin
            rd_mux = {20'h0_0000, pfn_q};
        end
    end

    always_comb begin
        ack_d = req & hit_any;
        err_d = req & ~hit_any;
        rdat_d = req ? rd_mux : rdat_q;
        rate_d = (wr && hit_rate) ? wb_dat_i[7:0] : rate_q;
        port_d = (wr && hit_port) ? wb_dat_i[3:0] : port_q;
        pfn_d = pfn_q;
        if (wr && hit_pfn) begin
            pfn_d[7:0] = wb_dat_i[7:0];
        end
        if (req && wb_we_i && wb_sel_i[1] && hit_pfn) begin
            pfn_d[11:8] = wb_dat_i[11:8];
        end
        ctrl_d = (wr && hit_ctrl) ? wb_dat_i[4:0] : ctrl_q;
        if (end_set_i || done_q) begin
            ctrl_d[SCB_END_BIT] = 1'b1; // set wins over clear
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            rate_q <= SCB_RATE_RST;
            port_q <= SCB_PORT_RST;
            pfn_q <= SCB_PFN_RST;
            ctrl_q <= SCB_CTRL_RST;
        end else begin
            ack_q <= ack_d;
            err_q <= err_d;
            rdat_q <= rdat_d;
            rate_q <= rate_d;
            port_q <= port_d;
            pfn_q <= pfn_d;
            ctrl_q <= ctrl_d;
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign wb_dat_o = rdat_q;

    ////////////////////////////////////////////////////////////////////////////
    // serial clock generator
    always_comb begin
        half_lim = {2'b00, rate_q[SCB_DIV_HI:0]};
        if (rate_q[SCB_SPEED_BIT]) begin
            half_lim = 7'(SCB_STD_MULT * (rate_q[SCB_DIV_HI:0] + 6'd1) - 1);
        end
    end
    // sync mode also uses the prescale field, so ticks come every prescale+1 system clocks
    assign tick = pre_q == rate_q[SCB_PRE_HI:SCB_PRE_LO];
    assign ext_mode = sync_mode & ~master;

    always_comb begin
        pre_d = pre_q;
        div_d = div_q;
        sck_d = sck_q;
        ext_d = ext_clk_i;
        if (!run || ext_mode) begin
            pre_d = 2'b00;
            div_d = 7'h00;
            sck_d = 1'b1;
        end else begin
            pre_d = tick ? 2'b00 : pre_q + 2'b01;
            if (tick) begin
                if (div_q >= half_lim) begin
                    div_d = 7'h00;
                    sck_d = ~sck_q;
                end else begin
                    div_d = div_q + 7'h01;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_q <= 2'b00;
            div_q <= 7'h00;
            sck_q <= 1'b1;
            ext_q <= 1'b1;
        end else begin
            pre_q <= pre_d;
            div_q <= div_d;
            sck_q <= sck_d;
            ext_q <= ext_d;
        end
    end

    assign sck_fall = ext_mode ? (ext_q & ~ext_clk_i) : (sck_q & ~sck_d);
    assign sck_rise = ext_mode ? (~ext_q & ext_clk_i) : (~sck_q & sck_d);

    ////////////////////////////////////////////////////////////////////////////
    // shifters and data buffer
    always_comb begin
        buf_d = buf_wr ? wb_dat_i[7:0] : buf_q;
        tx_d = tx_q;
        rx_d = rx_q;
        cnt_d = cnt_q;
        done_d = 1'b0;
        if (sck_rise) begin
            rx_d = {rx_q[6:0], sda_i};
            if (sync_mode && cnt_q == 4'(SCB_BITS)) begin
                buf_d = {rx_q[6:0], sda_i};
                done_d = 1'b1;
                cnt_d = 4'h0;
            end
        end
        if (sck_fall) begin
            tx_d = {tx_q[6:0], 1'b1};
            cnt_d = (cnt_q == 4'(SCB_BITS)) ? 4'h0 : cnt_q + 4'h1;
            if (!sync_mode && cnt_q == 4'(SCB_BITS - 1)) begin
                buf_d = rx_q;
                done_d = 1'b1;
            end
        end
        // a stopped generator forgets any partial byte count
        if (!run && !ext_mode) begin
            cnt_d = 4'h0;
        end
        if (!sync_mode && xmit && (start_det_i || (buf_wr && end_flag))) begin
            tx_d = buf_d;
            cnt_d = 4'h0;
        end
        if (sync_mode && xmit && buf_wr && !master) begin
            tx_d = buf_d;
            cnt_d = 4'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_q <= SCB_DATA_RST;
            tx_q <= 8'hff;
            rx_q <= 8'h00;
            cnt_q <= 4'h0;
            done_q <= 1'b0;
        end else begin
            buf_q <= buf_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            cnt_q <= cnt_d;
            done_q <= done_d;
        end
    end
    assign xfer_done_o = done_q;

    ////////////////////////////////////////////////////////////////////////////
    // port configuration
    assign slow_drive_o = port_q[SCB_SLOW_BIT];
    assign cmos_threshold_o = port_q[SCB_THR_BIT];
    assign port_voltage_o = port_q[SCB_PV_BIT];
    assign sda_hold_adjust_o = port_q[SCB_HOLD_BIT];
    assign sda_in_en_o = 1'b1;

    // pfn bits per pin: [3]=function a, [2]=function b, [1]=latch, [0]=direction
    scb_pin_cfg u_clk_pin (
        .fsa_i(pfn_q[3]),
        .fsb_i(pfn_q[2]),
        .lat_i(pfn_q[1]),
        .ddr_i(pfn_q[0]),
        .slow_force_i(port_q[SCB_SLOW_BIT]),
        .val_i(sck_q),
        .type_o(),
        .out_o(scl_o),
        .oe_o(scl_oe_o)
    );
    scb_pin_cfg u_data_pin (
        .fsa_i(pfn_q[7]),
        .fsb_i(pfn_q[6]),
        .lat_i(pfn_q[5]),
        .ddr_i(pfn_q[4]),
        .slow_force_i(port_q[SCB_SLOW_BIT]),
        .val_i(tx_q[7]),
        .type_o(),
        .out_o(sda_o),
        .oe_o(sda_oe_o)
    );
    scb_pin_cfg u_out_pin (
        .fsa_i(pfn_q[11]),
        .fsb_i(pfn_q[10]),
        .lat_i(pfn_q[9]),
        .ddr_i(pfn_q[8]),
        .slow_force_i(1'b0),
        .val_i(tx_q[7]),
        .type_o(),
        .out_o(sdo_o),
        .oe_o(sdo_oe_o)
    );
endmodule

// ===== scb_monitor.sv
/*
 port checker for the serial clock and buffer block.
 assumes it is bound into scb_top.
*/
`timescale 1ns/100ps
module scb_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic scl_o,
    input wire logic scl_oe_o,
    input wire logic sda_oe_o,
    input wire logic sdo_oe_o,
    input wire logic sda_in_en_o,
    input wire logic xfer_done_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
        else $error("request not answered in one cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    err_cause_a: assert property (wb_err_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("err without request");
    resp_excl_a: assert property (!(wb_ack_o && wb_err_o))
        else $error("ack and err together");
    reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !scl_oe_o && !sda_oe_o && !sdo_oe_o)
        else $error("outputs active after reset");
    data_input_a: assert property (sda_in_en_o)
        else $error("data input disabled");
    clock_high_a: assert property ($rose(scl_o) |=> scl_o)
        else $error("clock high half too short");
    done_pulse_a: assert property (xfer_done_o |=> !xfer_done_o)
        else $error("done pulse too long");
endmodule

// ===== scb_bus_peer.sv
/*
 far side serial device: sends one byte msb first.
 assumes pull-ups on both lines.
*/
`timescale 1ns/100ps
module scb_bus_peer (
    input wire logic rst_i,
    input wire logic scl_o,
    input wire logic scl_oe_o,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic [7:0] byte_i,
    output logic scl_i,
    output logic sda_i
);
    logic [2:0] idx;
    // released lines float high through the pull-ups
    assign scl_i = scl_oe_o ? scl_o : 1'b1;
    assign sda_i = (sda_oe_o ? sda_o : 1'b1) & byte_i[idx];
    // next bit after each falling clock, first fall shows bit 7
    always @(negedge scl_i or posedge rst_i) begin
        if (rst_i) begin
            idx <= 3'd0;
        end else begin
            idx <= idx - 3'd1;
        end
    end
endmodule

// ===== tb.sv
/*
 self-checking bench for scb_top.
 assumes wishbone answers one cycle after the request edge.
*/
`timescale 1ns/100ps
module tb;
    import scb_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, rsp_err;
    logic start_det_i, end_set_i, ext_clk_i;
    logic [3:0] wb_sel_i;
    logic [17:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic scl_i, scl_o, scl_oe_o, sda_i, sda_o, sda_oe_o, sdo_o, sdo_oe_o, sda_in_en_o;
    logic cmos_threshold_o, slow_drive_o, port_voltage_o, sda_hold_adjust_o, filter_en_o, xfer_done_o;
    logic [7:0] rx_byte, tx_byte;
    logic [3:0] nib [5] = '{4'hf, 4'h9, 4'he, 4'hd, 4'h0};
    logic oe_exp [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    int err_count, total_checks, seed, k;
    scb_top i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .start_det_i(start_det_i), .end_set_i(end_set_i),
        .ext_clk_i(ext_clk_i), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .sda_in_en_o(sda_in_en_o),
        .cmos_threshold_o(cmos_threshold_o), .slow_drive_o(slow_drive_o), .port_voltage_o(port_voltage_o),
        .sda_hold_adjust_o(sda_hold_adjust_o), .filter_en_o(filter_en_o), .xfer_done_o(xfer_done_o)
    );
    scb_bus_peer i_peer (
        .rst_i(rst_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .byte_i(rx_byte), .scl_i(scl_i), .sda_i(sda_i)
    );
    ////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic hang(input string what);
        err_count++;
        $display("wrong value at %0t: %s timed out", $time, what);
        tally_and_finish();
    endtask
    task automatic wb(input logic we, input logic [17:0] adr, input logic [31:0] dat);
        int i;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_sel_i <= 4'hf;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        for (i = 0; i < 20 && wb_ack_o !== 1'b1 && wb_err_o !== 1'b1; i++) @(posedge clk_i);
        if (i == 20) hang("bus");
        rd = wb_dat_o;
        rsp_err = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wait_lvl(input logic v, output int c);
        for (c = 0; c < 3000 && scl_o !== v; c++) @(posedge clk_i);
        if (c == 3000) hang("clock");
    endtask
    function automatic int half_of(input logic [1:0] p, input logic s, input logic [4:0] n);
        return (p + 1) * (n + 1) * (s ? SCB_STD_MULT : 1);
    endfunction
    task automatic clk_case(input logic [1:0] p, input logic s, input logic [4:0] n, input logic mode);
        logic [31:0] ctl;
        int c;
        ctl = '0;
        ctl[SCB_RUN_BIT] = 1'b1;
        ctl[SCB_MST_BIT] = 1'b1;
        ctl[SCB_MODE_BIT] = mode;
        wb(1'b1, SCB_ADR_CTRL, 32'h0);
        wb(1'b1, SCB_ADR_RATE, {24'h0, p, s, n});
        wb(1'b1, SCB_ADR_CTRL, ctl);
        chk(32'(filter_en_o), 32'(!mode), "filter");
        wait_lvl(1'b1, c);
        wait_lvl(1'b0, c);
        wait_lvl(1'b1, c);
        chk(c, half_of(p, s, n), "low half");
        wait_lvl(1'b0, c);
        chk(c, half_of(p, s, n), "high half");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        seed = 95433;
        rx_byte = 8'h00;
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        {wb_sel_i, start_det_i, end_set_i} = '0;
        ext_clk_i = 1'b1;
        rst_i = 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, SCB_ADR_DATA, 32'h0);
        chk(rd, 32'(SCB_DATA_RST), "buffer reset");
        wb(1'b0, SCB_ADR_PORT, 32'h0);
        chk(rd, 32'(SCB_PORT_RST), "port reset");
        repeat (4) begin
            rx_byte = 8'($random(seed));
            wb(1'b1, SCB_ADR_DATA, {24'h0, rx_byte});
            wb(1'b0, SCB_ADR_DATA, 32'h0);
            chk(rd, {24'h0, rx_byte}, "buffer");
        end
        wb(1'b1, 18'h0, 32'hff);
        chk(32'(rsp_err), 32'h1, "unmapped");
        wb(1'b1, SCB_ADR_PORT, 32'h7);
        chk(32'({sda_hold_adjust_o, port_voltage_o, cmos_threshold_o, slow_drive_o}), 32'h7, "port bits");
        $display("test registers done");
        clk_case(2'd0, 1'b0, 5'd4, 1'b0);
        clk_case(2'd3, 1'b1, 5'd31, 1'b0);
        clk_case(2'd0, 1'b0, 5'd1, 1'b1);
        clk_case(2'd0, 1'b1, 5'd1, 1'b1);
        repeat (3) clk_case(2'($random(seed)), 1'($random(seed)), 5'd4 + 5'($unsigned($random(seed)) % 28), 1'b0);
        wb(1'b1, SCB_ADR_CTRL, 32'h0);
        $display("test clock done");
        for (k = 0; k < 5; k++) begin
            wb(1'b1, SCB_ADR_PFN, {20'h0, nib[k], nib[k], nib[k]});
            chk(32'(scl_oe_o), 32'(oe_exp[k]), "clock pin drive");
            chk(32'(sda_oe_o), 32'(oe_exp[k]), "data pin drive");
            chk(32'(sdo_oe_o), 32'(oe_exp[k]), "data out pin drive");
        end
        $display("test pins done");
        rx_byte = 8'($random(seed));
        wb(1'b1, SCB_ADR_PFN, 32'h0f9);
        wb(1'b1, SCB_ADR_RATE, 32'h01);
        wb(1'b1, SCB_ADR_CTRL, 32'h13);
        for (k = 0; k < 2000 && xfer_done_o !== 1'b1; k++) @(posedge clk_i);
        if (k == 2000) hang("receive");
        wb(1'b1, SCB_ADR_CTRL, 32'h0);
        wb(1'b0, SCB_ADR_DATA, 32'h0);
        chk(rd, {24'h0, rx_byte}, "received byte");
        $display("test receive done");
        tx_byte = 8'($random(seed));
        wb(1'b1, SCB_ADR_PFN, 32'h900);
        wb(1'b1, SCB_ADR_CTRL, 32'h05);
        wb(1'b1, SCB_ADR_DATA, {24'h0, tx_byte});
        for (k = 7; k >= 0; k--) begin
            chk(32'(sdo_o), 32'(tx_byte[k]), "serial out bit");
            ext_clk_i <= 1'b0;
            repeat (2) @(posedge clk_i);
            ext_clk_i <= 1'b1;
            repeat (2) @(posedge clk_i);
        end
        wb(1'b0, SCB_ADR_CTRL, 32'h0);
        chk(rd, 32'h0d, "end flag after eighth rise");
        wb(1'b1, SCB_ADR_CTRL, 32'h04);
        wb(1'b1, SCB_ADR_DATA, 32'h5a);
        chk(32'(sdo_o), 32'h1, "load without start");
        start_det_i <= 1'b1;
        @(posedge clk_i);
        start_det_i <= 1'b0;
        @(posedge clk_i);
        chk(32'(sdo_o), 32'h0, "load on start");
        chk(32'(sda_o), 32'h0, "data pin value");
        end_set_i <= 1'b1;
        @(posedge clk_i);
        end_set_i <= 1'b0;
        wb(1'b1, SCB_ADR_DATA, 32'ha5);
        chk(32'(sdo_o), 32'h1, "load on write with end set");
        $display("test transmit done");
        tally_and_finish();
    end
endmodule
bind scb_top scb_monitor i_mon (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o), .sdo_oe_o(sdo_oe_o),
    .sda_in_en_o(sda_in_en_o), .xfer_done_o(xfer_done_o)
);
